// ---- rtl/supervisor_pkg.sv ----
// shared constants and carrier types for the supervisor block
package supervisor_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int RESET_TIMEOUT_MS = 200;
	localparam int DOG_TIMEOUT_MS = 1600;
	localparam int PB_MIN_NS = 150;
	localparam int PB_MAX_NS = 250;
	localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
	// timebase tick every 1 ms
	localparam int TICK_CYCLES = CLK_HZ / 1000;
	// least time rounds up, longest rounds down
	localparam int PB_MIN_CYCLES = (PB_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int PB_MAX_CYCLES = PB_MAX_NS / CLK_NS;
	localparam int PB_CNT_W = 5;
	localparam int MS_CNT_W = 12;
	localparam int TICK_W = 17;

	typedef struct packed {
		logic supply_low;
		logic pushbutton_n;
		logic kick;
		logic kick_driven;
		logic pf_above;
	} sup_in_s;

	typedef struct packed {
		logic sys_reset_n;
		logic sys_reset;
		logic dog_expired_n;
		logic power_fail_warn_n;
	} sup_out_s;
endpackage

// ---- rtl/pb_debounce.sv ----
// pushbutton reset debouncer: low must persist before it counts
`timescale 1ns/1ps
module pb_debounce #(
	parameter int MIN_CYCLES = supervisor_pkg::PB_MIN_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic raw_n,
	output logic clean_n
);
	typedef struct packed {
		logic [supervisor_pkg::PB_CNT_W-1:0] cnt;
		logic clean_n;
	} deb_s;

	deb_s st_reg;
	deb_s st_next;

	always_comb
	begin
		st_next = st_reg;
		if (raw_n)
		begin
			st_next.cnt = '0;
			st_next.clean_n = 1'b1;
		end
		else if (st_reg.cnt >= MIN_CYCLES[supervisor_pkg::PB_CNT_W-1:0] - 1'b1)
		begin
			st_next.clean_n = 1'b0;
		end
		else
		begin
			st_next.cnt = st_reg.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= '{cnt: '0, clean_n: 1'b1};
		else if (ce)
			st_reg <= st_next;
	end

	assign clean_n = st_reg.clean_n;
endmodule // pb_debounce

// ---- rtl/supervisor_reset_watchdog.sv ----
// supervisor top: reset stretch, watchdog, power-fail warning
`timescale 1ns/1ps
module supervisor_reset_watchdog #(
	parameter int TICK_CYCLES = supervisor_pkg::TICK_CYCLES,
	parameter int RESET_MS = supervisor_pkg::RESET_TIMEOUT_MS,
	parameter int DOG_MS = supervisor_pkg::DOG_TIMEOUT_MS
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic SUPPLY_LOW,
	input wire logic PUSHBUTTON_RESET_N,
	input wire logic KICK_INPUT,
	input wire logic KICK_DRIVEN,
	input wire logic POWER_FAIL_SENSE,
	output logic SYS_RESET_N,
	output logic SYS_RESET,
	output logic DOG_EXPIRED_N,
	output logic POWER_FAIL_WARN_N
);
	localparam int MW = supervisor_pkg::MS_CNT_W;
	localparam int TW = supervisor_pkg::TICK_W;

	typedef enum logic [1:0] {
		ST_HOLD = 2'b01,
		ST_RUN = 2'b10
	} rst_state_e;

	typedef struct packed {
		rst_state_e state;
		logic [TW-1:0] tick_cnt;
		logic tick;
		logic [MW-1:0] rst_ms;
		logic [MW-1:0] dog_ms;
		logic kick_prev;
		supervisor_pkg::sup_out_s out;
	} top_s;

	top_s st_reg;
	top_s st_next;
	supervisor_pkg::sup_in_s in_w;
	logic pb_clean_n;
	logic cause;
	logic kick_step_w;

	assign in_w = '{supply_low: SUPPLY_LOW, pushbutton_n: PUSHBUTTON_RESET_N,
		kick: KICK_INPUT, kick_driven: KICK_DRIVEN,
		pf_above: POWER_FAIL_SENSE};

	////////////////////////////////////////////////////////////////////////
	pb_debounce #(
		.MIN_CYCLES(supervisor_pkg::PB_MIN_CYCLES)
	) u_deb (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.ce(CE),
		.raw_n(in_w.pushbutton_n),
		.clean_n(pb_clean_n)
	);

	// reset causes; dog expiry deliberately not included
	assign cause = in_w.supply_low | ~pb_clean_n;
	assign kick_step_w = in_w.kick != st_reg.kick_prev;

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		st_next = st_reg;
		// free-running 1 ms timebase
		st_next.tick = 1'b0;
		if (st_reg.tick_cnt == TW'(TICK_CYCLES - 1))
		begin
			st_next.tick_cnt = '0;
			st_next.tick = 1'b1;
		end
		else
		begin
			st_next.tick_cnt = st_reg.tick_cnt + 1'b1;
		end

		// reset stretch
		case (st_reg.state)
			ST_HOLD:
			begin
				if (cause)
					st_next.rst_ms = '0;
				else if (st_reg.tick)
					st_next.rst_ms = st_reg.rst_ms + 1'b1;
				if (!cause && st_reg.rst_ms >= MW'(RESET_MS))
					st_next.state = ST_RUN;
			end
			ST_RUN:
			begin
				if (cause)
				begin
					st_next.state = ST_HOLD;
					st_next.rst_ms = '0;
				end
			end
			default:
			begin
				st_next.state = ST_HOLD;
				st_next.rst_ms = '0;
			end
		endcase
		st_next.out.sys_reset_n = !(cause || st_next.state != ST_RUN);
		st_next.out.sys_reset = !st_next.out.sys_reset_n;

		// watchdog
		st_next.kick_prev = in_w.kick;
		if (!in_w.kick_driven || in_w.kick != st_reg.kick_prev)
			st_next.dog_ms = '0;
		else if (st_reg.tick && st_reg.dog_ms <= MW'(DOG_MS))
			st_next.dog_ms = st_reg.dog_ms + 1'b1;
		st_next.out.dog_expired_n = !(in_w.supply_low ||
			st_next.dog_ms > MW'(DOG_MS));

		// comparator result only
		st_next.out.power_fail_warn_n = in_w.pf_above;
	end

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			st_reg.state <= ST_HOLD;
			st_reg.tick_cnt <= '0;
			st_reg.tick <= 1'b0;
			st_reg.rst_ms <= '0;
			st_reg.dog_ms <= '0;
			st_reg.kick_prev <= 1'b0;
			st_reg.out <= '{sys_reset_n: 1'b0, sys_reset: 1'b1,
				dog_expired_n: 1'b1, power_fail_warn_n: 1'b1};
		end
		else if (CE)
			st_reg <= st_next;
	end

	assign SYS_RESET_N = st_reg.out.sys_reset_n;
	assign SYS_RESET = st_reg.out.sys_reset;
	assign DOG_EXPIRED_N = st_reg.out.dog_expired_n;
	assign POWER_FAIL_WARN_N = st_reg.out.power_fail_warn_n;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N || !CE);

	// a pushbutton low only counts after 15 samples in a row
	sequence pb_low_head;
		!PUSHBUTTON_RESET_N [*8];
	endsequence

	sequence pb_low_tail;
		!PUSHBUTTON_RESET_N [*7];
	endsequence

	sequence pb_low_held;
		pb_low_head ##1 pb_low_tail;
	endsequence

	sequence kick_step;
		KICK_DRIVEN && KICK_INPUT != st_reg.kick_prev;
	endsequence

	sequence supply_low_pair;
		SUPPLY_LOW ##1 SUPPLY_LOW;
	endsequence

	a_reset_complement: assert property (SYS_RESET == !SYS_RESET_N)
		else $error("active-high reset not complement");
	a_supply_reset: assert property (SUPPLY_LOW |=> !SYS_RESET_N)
		else $error("reset not asserted on supply low");
	a_pb_assert: assert property (pb_low_held
		|-> ##[0:10] !SYS_RESET_N)
		else $error("pushbutton reset too slow");
	a_pb_glitch: assert property ($rose(PUSHBUTTON_RESET_N) ##1
		!PUSHBUTTON_RESET_N ##1 PUSHBUTTON_RESET_N && !SUPPLY_LOW &&
		SYS_RESET_N && $past(SYS_RESET_N, 2) |=> SYS_RESET_N)
		else $error("short pushbutton glitch caused reset");
	a_stretch_hold: assert property ($fell(cause) |=> !SYS_RESET_N [*8])
		else $error("reset released early");
	a_dog_supply: assert property (SUPPLY_LOW |=> !DOG_EXPIRED_N)
		else $error("dog expiry not low on supply low");
	a_dog_kick: assert property (KICK_DRIVEN && !SUPPLY_LOW &&
		$changed(KICK_INPUT) |=> ##1 DOG_EXPIRED_N || SUPPLY_LOW)
		else $error("kick edge did not restart watchdog");
	a_dog_float: assert property (!KICK_DRIVEN && !SUPPLY_LOW
		|=> DOG_EXPIRED_N)
		else $error("floating kick expired watchdog");
	a_pf_follow: assert property ($past(RST_N) |->
		POWER_FAIL_WARN_N == $past(POWER_FAIL_SENSE))
		else $error("power fail warning mismatch");
	a_dog_no_reset: assert property (!SUPPLY_LOW && pb_clean_n &&
		st_reg.state == ST_RUN && $fell(DOG_EXPIRED_N) |-> SYS_RESET_N)
		else $error("expiry asserted reset");

	////////////////////////////////////////////////////////////////////////
	// timebase: one tick per TICK_CYCLES clocks
	a_tick_wrap: assert property (st_reg.tick |->
		st_reg.tick_cnt == '0)
		else $error("tick not aligned to counter wrap");

	a_tick_range: assert property (
		st_reg.tick_cnt < TW'(TICK_CYCLES))
		else $error("timebase counter out of range");

	a_tick_single: assert property (st_reg.tick |=>
		!st_reg.tick)
		else $error("tick lasted more than one cycle");

	a_tick_due: assert property (
		st_reg.tick_cnt == TW'(TICK_CYCLES - 1) |=> st_reg.tick)
		else $error("tick missing at counter wrap");

	// reset stretch
	a_cause_hold: assert property (cause |=>
		st_reg.state == ST_HOLD && st_reg.rst_ms == '0)
		else $error("cause did not restart the stretch");

	a_release_count: assert property ($rose(SYS_RESET_N) |->
		st_reg.rst_ms >= MW'(RESET_MS))
		else $error("reset released before timeout");

	a_release_clean: assert property ($rose(SYS_RESET_N) |->
		!$past(cause))
		else $error("reset released with cause present");

	a_hold_steady: assert property (st_reg.state == ST_HOLD &&
		!cause && !st_reg.tick |=> $stable(st_reg.rst_ms))
		else $error("stretch counted without a tick");

	a_pb_release: assert property ($rose(pb_clean_n) |=>
		!SYS_RESET_N)
		else $error("no stretch after pushbutton release");

	a_run_released: assert property (st_reg.state == ST_RUN |->
		SYS_RESET_N)
		else $error("reset low in run state");

	a_state_onehot: assert property (
		$onehot(st_reg.state))
		else $error("stretch state not one-hot");

	a_supply_pair: assert property (supply_low_pair |->
		!SYS_RESET_N && !DOG_EXPIRED_N)
		else $error("outputs high during supply low");

	// pushbutton debounce
	a_pb_qualified: assert property ($fell(pb_clean_n) |->
		!$past(PUSHBUTTON_RESET_N) &&
		!$past(PUSHBUTTON_RESET_N, supervisor_pkg::PB_MIN_CYCLES))
		else $error("debounced low without a long enough press");

	a_pb_follow: assert property (PUSHBUTTON_RESET_N |=>
		pb_clean_n)
		else $error("debounced button stuck low");

	a_pb_reset: assert property (!pb_clean_n |=>
		!SYS_RESET_N)
		else $error("debounced press did not reset");

	// watchdog
	a_kick_restart: assert property (kick_step |=>
		st_reg.dog_ms == '0)
		else $error("kick edge did not clear idle count");

	a_float_clear: assert property (!KICK_DRIVEN |=>
		st_reg.dog_ms == '0)
		else $error("floating kick left idle count running");

	a_dog_saturate: assert property (
		st_reg.dog_ms <= MW'(DOG_MS + 1))
		else $error("idle count ran past saturation");

	a_dog_expire_why: assert property (!DOG_EXPIRED_N &&
		!$past(SUPPLY_LOW) |-> st_reg.dog_ms > MW'(DOG_MS))
		else $error("expiry without idle timeout");

	a_dog_idle_step: assert property (KICK_DRIVEN &&
		!kick_step_w && !st_reg.tick |=> $stable(st_reg.dog_ms))
		else $error("idle count moved without a tick");

	a_dog_expire_due: assert property (st_reg.dog_ms > MW'(DOG_MS) &&
		KICK_DRIVEN && !kick_step_w |=> !DOG_EXPIRED_N)
		else $error("idle timeout did not expire");

	a_dog_recover: assert property (!SUPPLY_LOW ##0 kick_step |=>
		DOG_EXPIRED_N)
		else $error("kick edge did not clear expiry");

	a_kick_track: assert property ($past(RST_N) |->
		st_reg.kick_prev == $past(KICK_INPUT))
		else $error("kick history not tracking input");
endmodule // supervisor_reset_watchdog

// ---- verif/kick_host.sv ----
// host model: drives the watchdog kick pin and its float state
`timescale 1ns/1ps
module kick_host (
	input wire logic clk,
	input wire logic run,
	input wire logic poke,
	input wire logic float_n,
	output logic kick,
	output logic driven
);
	logic kick_reg = 1'b0;
	logic [5:0] cnt_reg = 6'h00;
	////////////////////////////////////////
	// toggles every 50 cycles while run, once per poke pulse
	// a floating pin wanders every cycle, so it must be ignored
	always_ff @(posedge clk)
	begin
		cnt_reg <= (cnt_reg == 6'h31 || !run) ? 6'h00 : cnt_reg + 6'h01;
		if ((run && cnt_reg == 6'h31) || poke || !float_n)
			kick_reg <= ~kick_reg;
	end
	assign kick = kick_reg;
	assign driven = float_n;
endmodule // kick_host

// ---- verif/test_supervisor_reset_watchdog.sv ----
// self-checking bench for the supervisor block
`timescale 1ns/1ps
module test_supervisor_reset_watchdog;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic supply_low = 1'b0;
	logic pb_n = 1'b1;
	logic sense = 1'b1;
	logic run = 1'b1;
	logic poke = 1'b0;
	logic float_n = 1'b1;
	logic kick, driven, rst_o_n, rst_o, dog_n, warn_n;
	int bad_count = 0;
	int comparisons = 0;
	// supply_low, button, sense | reset_n, dog_n, warn_n
	logic [5:0] rows [6] = '{6'h1F, 6'h16, 6'h39, 6'h02, 6'h29, 6'h1F};
	////////////////////////////////////////
	always #5 sys_clk = ~sys_clk;
	kick_host host_u (.clk(sys_clk), .run(run), .poke(poke),
		.float_n(float_n), .kick(kick), .driven(driven));
	supervisor_reset_watchdog #(.TICK_CYCLES(10), .RESET_MS(5),
		.DOG_MS(20)) dut_u (.SYS_CLK(sys_clk), .RST_N(rst_n), .CE(1'b1),
		.SUPPLY_LOW(supply_low), .PUSHBUTTON_RESET_N(pb_n),
		.KICK_INPUT(kick), .KICK_DRIVEN(driven),
		.POWER_FAIL_SENSE(sense), .SYS_RESET_N(rst_o_n),
		.SYS_RESET(rst_o), .DOG_EXPIRED_N(dog_n),
		.POWER_FAIL_WARN_N(warn_n));
	////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic look(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input logic got, input logic exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic pulse();
		cyc(1);
		poke <= 1'b1;
		cyc(1);
		poke <= 1'b0;
	endtask
	task automatic results();
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////
	initial
	begin
		repeat (6000) @(posedge sys_clk);
		bad_count++;
		results();
	end
	initial
	begin
		look(1);
		chk(rst_o_n, 1'b0);
		chk(rst_o, 1'b1);
		chk(dog_n, 1'b1);
		chk(warn_n, 1'b1);
		cyc(15);
		rst_n <= 1'b1;
		look(40);
		chk(rst_o_n, 1'b0);
		look(30);
		chk(rst_o_n, 1'b1);
		$display("test reset done");
		foreach (rows[i])
		begin
			cyc(1);
			{supply_low, pb_n, sense} <= rows[i][5:3];
			look(100);
			chk(rst_o_n, rows[i][2]);
			chk(rst_o, ~rows[i][2]);
			chk(dog_n, rows[i][1]);
			chk(warn_n, rows[i][0]);
			$display("row %0d done", i);
		end
		cyc(1);
		pb_n <= 1'b0;
		cyc(10);
		pb_n <= 1'b1;
		look(20);
		chk(rst_o_n, 1'b1);
		cyc(1);
		pb_n <= 1'b0;
		look(25);
		chk(rst_o_n, 1'b0);
		cyc(1);
		pb_n <= 1'b1;
		look(40);
		chk(rst_o_n, 1'b0);
		look(30);
		chk(rst_o_n, 1'b1);
		$display("test button done");
		cyc(1);
		run <= 1'b0;
		repeat (2)
		begin
			cyc(120);
			pulse();
		end
		look(150);
		chk(dog_n, 1'b1);
		look(80);
		chk(dog_n, 1'b0);
		chk(rst_o_n, 1'b1);
		pulse();
		look(3);
		chk(dog_n, 1'b1);
		cyc(1);
		float_n <= 1'b0;
		look(300);
		chk(dog_n, 1'b1);
		chk(rst_o_n, 1'b1);
		$display("test watchdog done");
		cyc(1);
		rst_n <= 1'b0;
		look(2);
		chk(rst_o_n, 1'b0);
		chk(rst_o, 1'b1);
		chk(dog_n, 1'b1);
		cyc(1);
		rst_n <= 1'b1;
		look(40);
		chk(rst_o_n, 1'b0);
		look(30);
		chk(rst_o_n, 1'b1);
		$display("test second reset done");
		results();
	end
endmodule // test_supervisor_reset_watchdog
